// ==== lce_pkg.sv ====
// Constants, field layouts and types for the logic and compare execution unit.
// Assumes a single 100 MHz clock and an APB requester on the same clock.
package lce_pkg;

    // ------------------------------------------------------------------
    // Data widths
    // ------------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int DBL_W = 64;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDRF_W = 18;
    localparam int PADDR_W = 8;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_XOR_ACC = 8'h27;
    localparam logic [7:0] OP_XOR_HALF = 8'h33;
    localparam logic [7:0] OP_XOR_BYTE = 8'h23;
    localparam logic [7:0] OP_XOR_STORE = 8'h65;
    localparam logic [7:0] OP_COMPL = 8'h3B;
    localparam logic [7:0] OP_CMP_AND = 8'h34;
    localparam logic [7:0] OP_CMP_LACC = 8'h17;
    localparam logic [7:0] OP_CMP_LHALF = 8'h10;

    // ------------------------------------------------------------------
    // Select field codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_MEM = 2'h0;
    localparam logic [1:0] SEL_A = 2'h1;
    localparam logic [1:0] SEL_B = 2'h2;
    localparam logic [1:0] SEL_D = 2'h3;
    localparam logic [1:0] HALF_LEFT = 2'h1;
    localparam logic [1:0] HALF_RIGHT = 2'h2;
    localparam logic [1:0] HALF_SEXT = 2'h3;

    // ------------------------------------------------------------------
    // Condition indicator values
    // ------------------------------------------------------------------
    localparam logic [1:0] CI_1 = 2'h1;
    localparam logic [1:0] CI_2 = 2'h2;
    localparam logic [1:0] CI_3 = 2'h3;
    localparam logic [1:0] CI_RESET = 2'h2;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [PADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [PADDR_W-1:0] OFS_ADDRF = 8'h04;
    localparam logic [PADDR_W-1:0] OFS_OPND_LO = 8'h08;
    localparam logic [PADDR_W-1:0] OFS_OPND_HI = 8'h0C;
    localparam logic [PADDR_W-1:0] OFS_ACC_A = 8'h10;
    localparam logic [PADDR_W-1:0] OFS_ACC_B = 8'h14;
    localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h18;
    localparam logic [PADDR_W-1:0] OFS_STORE_LO = 8'h1C;
    localparam logic [PADDR_W-1:0] OFS_STORE_HI = 8'h20;

    // ------------------------------------------------------------------
    // Control and status field positions
    // ------------------------------------------------------------------
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_M_LSB = 8;
    localparam int CTRL_C_BIT = 10;
    localparam int CTRL_L_BIT = 11;
    localparam int CTRL_I_BIT = 12;
    localparam int CTRL_X_LSB = 13;
    localparam int CTRL_GO_BIT = 31;
    localparam int ST_CI_LSB = 0;
    localparam int ST_DONE_BIT = 2;
    localparam int ST_ILL_BIT = 3;
    localparam int ST_STORE_BIT = 4;
    localparam int ST_DBL_BIT = 5;

    typedef enum logic {
        LCE_IDLE = 1'b0,
        LCE_EXEC = 1'b1
    } lce_state_e;

    typedef enum logic [1:0] {
        CSRC_LOGIC = 2'b00,
        CSRC_CMP = 2'b01,
        CSRC_CAND = 2'b10
    } lce_csrc_e;

endpackage : lce_pkg

// ==== lce_cond_eval.sv ====
// Condition indicator evaluation for word or double-word values.
// Assumes operands narrower than 64 bits arrive zero-extended.
`timescale 1ns/100ps
module lce_cond_eval (
    input wire logic [lce_pkg::DBL_W-1:0] lhs,
    input wire logic [lce_pkg::DBL_W-1:0] rhs,
    input wire logic [lce_pkg::DBL_W-1:0] res,
    input wire logic dbl,
    output logic [1:0] ci_logic,
    output logic [1:0] ci_cmp,
    output logic [1:0] ci_cand
);
    import lce_pkg::*;

    logic [DBL_W-1:0] res_m;
    logic [DBL_W-1:0] rhs_m;
    logic all_one;

    // ------------------------------------------------------------------
    // Width masking
    // ------------------------------------------------------------------
    assign res_m = dbl ? res : {{WORD_W{1'b0}}, res[WORD_W-1:0]};
    assign rhs_m = dbl ? rhs : {{WORD_W{1'b0}}, rhs[WORD_W-1:0]};
    assign all_one = dbl ? (&res) : (&res[WORD_W-1:0]);

    // ------------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------------
    always_comb begin
        if (all_one) begin
            ci_logic = CI_1;
        end else if (res_m == '0) begin
            ci_logic = CI_2;
        end else begin
            ci_logic = CI_3;
        end
    end

    // Unsigned: no sign bit treatment
    always_comb begin
        if (lhs < rhs) begin
            ci_cmp = CI_1;
        end else if (lhs == rhs) begin
            ci_cmp = CI_2;
        end else begin
            ci_cmp = CI_3;
        end
    end

    always_comb begin
        if (res_m == rhs_m) begin
            ci_cand = CI_1;
        end else if (res_m == '0) begin
            ci_cand = CI_2;
        end else begin
            ci_cand = CI_3;
        end
    end

endmodule : lce_cond_eval

// ==== lce_exec.sv ====
// Exclusive-OR, complement and logical compare execution unit with APB access.
// Assumes instruction control resolves the effective address and loads the
// memory operand, then starts the operation by a write to the control word.
`timescale 1ns/100ps

// Overview of operation
// - Opcode 27 XORs operand into accumulator
// - A, B use words; D uses double-words
// - Select 01 A, 10 B, 11 D
// - C=1 sets indicator all-ones/zeros/mixed
// - Literal sign-extends 18-bit address field
// - Opcode 33 XORs half-word into A half
// - Half select left, right, or sign-extended
// - Half literal uses low 16 address bits
// - Opcode 23 XORs byte; indicator whole A
// - Byte literal uses low 8 address bits
// - XOR to storage writes memory, keeps accumulator
// - Store forms refuse literal and indexing
// - Opcode 3B complements memory or accumulator
// - Complement ignores unused addressing fields
// - Opcode 34 ANDs and classifies, alters nothing
// - Compares without C=1 are no-operations
// - Opcode 17 unsigned compare, less/equal/greater
// - Opcode 10 compares selected half unsigned
// - Half compare literal uses low 16 bits
// - Comparative AND accepts all flags, no writes
module lce_exec (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lce_pkg::PADDR_W-1:0] paddr,
    input wire logic [lce_pkg::WORD_W-1:0] pwdata,
    output logic [lce_pkg::WORD_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [1:0] cond_ind,
    output logic store_wr,
    output logic store_dbl,
    output logic [lce_pkg::DBL_W-1:0] store_data
);
    import lce_pkg::*;

    lce_state_e state;
    logic [7:0] op;
    logic [1:0] msel, xsel;
    logic cbit, lbit, ibit, done, illegal;
    logic [ADDRF_W-1:0] addrf;
    logic [WORD_W-1:0] opnd_lo, opnd_hi, acc_a, acc_b;
    logic acc_phase, take, wr_take, go, mapped;
    logic [WORD_W-1:0] rd_mux, next_a, next_b;
    logic [DBL_W-1:0] lit64, mem_opnd, acc_val;
    logic [HALF_W-1:0] half_opnd, a_half;
    logic [BYTE_W-1:0] byte_opnd;
    logic [4:0] byte_sh;
    logic [DBL_W-1:0] next_store, ev_lhs, ev_rhs, ev_res;
    logic next_store_wr, next_store_dbl, next_illegal, ci_en, ev_dbl;
    lce_csrc_e csrc;
    logic [1:0] ci_logic, ci_cmp, ci_cand, next_ci;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    assign acc_phase = psel & penable & ~pready;
    assign take = psel & penable & pready;
    assign wr_take = take & pwrite & ~pslverr;
    assign go = wr_take & (paddr == OFS_CTRL) & pwdata[CTRL_GO_BIT] & (state == LCE_IDLE);

    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        unique case (paddr)
            OFS_CTRL: begin
                rd_mux[CTRL_OP_LSB +: 8] = op;
                rd_mux[CTRL_M_LSB +: 2] = msel;
                rd_mux[CTRL_C_BIT] = cbit;
                rd_mux[CTRL_L_BIT] = lbit;
                rd_mux[CTRL_I_BIT] = ibit;
                rd_mux[CTRL_X_LSB +: 2] = xsel;
            end
            OFS_ADDRF: rd_mux[ADDRF_W-1:0] = addrf;
            OFS_OPND_LO: rd_mux = opnd_lo;
            OFS_OPND_HI: rd_mux = opnd_hi;
            OFS_ACC_A: rd_mux = acc_a;
            OFS_ACC_B: rd_mux = acc_b;
            OFS_STATUS: begin
                rd_mux[ST_CI_LSB +: 2] = cond_ind;
                rd_mux[ST_DONE_BIT] = done;
                rd_mux[ST_ILL_BIT] = illegal;
                rd_mux[ST_STORE_BIT] = store_wr;
                rd_mux[ST_DBL_BIT] = store_dbl;
            end
            OFS_STORE_LO: rd_mux = store_data[WORD_W-1:0];
            OFS_STORE_HI: rd_mux = store_data[DBL_W-1:WORD_W];
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= acc_phase;
            pslverr <= acc_phase & ~mapped;
            if (acc_phase) begin
                prdata <= (mapped && !pwrite) ? rd_mux : '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Instruction and operand registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            {op, msel, cbit, lbit, ibit, xsel, addrf, opnd_lo, opnd_hi} <= '0;
        end else if (wr_take && state == LCE_IDLE) begin
            unique case (paddr)
                OFS_CTRL: begin
                    op <= pwdata[CTRL_OP_LSB +: 8];
                    msel <= pwdata[CTRL_M_LSB +: 2];
                    cbit <= pwdata[CTRL_C_BIT];
                    lbit <= pwdata[CTRL_L_BIT];
                    ibit <= pwdata[CTRL_I_BIT];
                    xsel <= pwdata[CTRL_X_LSB +: 2];
                end
                OFS_ADDRF: addrf <= pwdata[ADDRF_W-1:0];
                OFS_OPND_LO: opnd_lo <= pwdata;
                OFS_OPND_HI: opnd_hi <= pwdata;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= LCE_IDLE;
        end else begin
            unique case (state)
                LCE_IDLE: state <= go ? LCE_EXEC : LCE_IDLE;
                LCE_EXEC: state <= LCE_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Operand preparation
    // ------------------------------------------------------------------
    assign lit64 = {{(DBL_W-ADDRF_W){addrf[ADDRF_W-1]}}, addrf};
    assign half_opnd = lbit ? addrf[HALF_W-1:0] : opnd_lo[HALF_W-1:0];
    assign byte_opnd = lbit ? addrf[BYTE_W-1:0] : opnd_lo[BYTE_W-1:0];
    assign a_half = (msel == HALF_LEFT) ? acc_a[WORD_W-1:HALF_W] : acc_a[HALF_W-1:0];
    // Byte 0 is leftmost, so shift is (3 - select) bytes
    assign byte_sh = {~msel, 3'b000};

    always_comb begin
        unique case (msel)
            SEL_B: acc_val = {{WORD_W{1'b0}}, acc_b};
            SEL_D: acc_val = {acc_a, acc_b};
            default: acc_val = {{WORD_W{1'b0}}, acc_a};
        endcase
        if (msel == SEL_D) begin
            mem_opnd = lbit ? lit64 : {opnd_hi, opnd_lo};
        end else begin
            mem_opnd = lbit ? {{WORD_W{1'b0}}, lit64[WORD_W-1:0]} : {{WORD_W{1'b0}}, opnd_lo};
        end
    end

    // ------------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------------
    always_comb begin
        next_a = acc_a;
        next_b = acc_b;
        next_store = store_data;
        next_store_wr = 1'b0;
        next_store_dbl = store_dbl;
        next_illegal = 1'b0;
        ci_en = cbit;
        csrc = CSRC_LOGIC;
        ev_lhs = '0;
        ev_rhs = '0;
        ev_res = '0;
        ev_dbl = (msel == SEL_D);
        unique case (op)
            OP_XOR_ACC: begin
                if (msel == SEL_MEM) begin
                    next_illegal = 1'b1;
                end else begin
                    ev_res = acc_val ^ mem_opnd;
                    unique case (msel)
                        SEL_A: next_a = ev_res[WORD_W-1:0];
                        SEL_B: next_b = ev_res[WORD_W-1:0];
                        default: {next_a, next_b} = ev_res;
                    endcase
                end
            end
            OP_XOR_HALF: begin
                ev_dbl = 1'b0;
                unique case (msel)
                    HALF_LEFT: next_a = {acc_a[WORD_W-1:HALF_W] ^ half_opnd, acc_a[HALF_W-1:0]};
                    HALF_RIGHT: next_a = {acc_a[WORD_W-1:HALF_W], acc_a[HALF_W-1:0] ^ half_opnd};
                    HALF_SEXT: next_a = acc_a ^ {{HALF_W{half_opnd[HALF_W-1]}}, half_opnd};
                    default: next_illegal = 1'b1;
                endcase
                ev_res = {{WORD_W{1'b0}}, next_a};
            end
            OP_XOR_BYTE: begin
                ev_dbl = 1'b0;
                next_a = acc_a ^ ({{(WORD_W-BYTE_W){1'b0}}, byte_opnd} << byte_sh);
                ev_res = {{WORD_W{1'b0}}, next_a};
            end
            OP_XOR_STORE: begin
                // Store forms carry no literal and no index
                if (msel == SEL_MEM || lbit || xsel != 2'h0) begin
                    next_illegal = 1'b1;
                end else begin
                    ev_res = acc_val ^ mem_opnd;
                    next_store = ev_res;
                    next_store_wr = 1'b1;
                    next_store_dbl = (msel == SEL_D);
                end
            end
            OP_COMPL: begin
                if (msel == SEL_MEM) begin
                    // Literal flag ignored: memory word always used
                    ev_dbl = 1'b0;
                    ev_res = {{WORD_W{1'b0}}, ~opnd_lo};
                    next_store = ev_res;
                    next_store_wr = 1'b1;
                    next_store_dbl = 1'b0;
                end else begin
                    ev_res = ~acc_val;
                    unique case (msel)
                        SEL_A: next_a = ev_res[WORD_W-1:0];
                        SEL_B: next_b = ev_res[WORD_W-1:0];
                        default: {next_a, next_b} = ev_res;
                    endcase
                end
            end
            OP_CMP_AND: begin
                csrc = CSRC_CAND;
                if (msel == SEL_MEM) begin
                    next_illegal = 1'b1;
                end else begin
                    ev_res = acc_val & mem_opnd;
                    ev_rhs = mem_opnd;
                end
            end
            OP_CMP_LACC: begin
                csrc = CSRC_CMP;
                if (msel == SEL_MEM) begin
                    next_illegal = 1'b1;
                end else begin
                    ev_lhs = acc_val;
                    ev_rhs = mem_opnd;
                end
            end
            OP_CMP_LHALF: begin
                csrc = CSRC_CMP;
                if (msel != HALF_LEFT && msel != HALF_RIGHT) begin
                    next_illegal = 1'b1;
                end else begin
                    ev_lhs = {{(DBL_W-HALF_W){1'b0}}, a_half};
                    ev_rhs = {{(DBL_W-HALF_W){1'b0}}, half_opnd};
                end
            end
            default: next_illegal = 1'b1;
        endcase
        if (next_illegal) begin
            next_a = acc_a;
            next_b = acc_b;
            next_store = store_data;
            next_store_wr = 1'b0;
            next_store_dbl = store_dbl;
            ci_en = 1'b0;
        end
    end

    lce_cond_eval u_eval (.lhs(ev_lhs), .rhs(ev_rhs), .res(ev_res), .dbl(ev_dbl), .ci_logic(ci_logic),
        .ci_cmp(ci_cmp), .ci_cand(ci_cand));

    always_comb begin
        unique case (csrc)
            CSRC_CMP: next_ci = ci_cmp;
            CSRC_CAND: next_ci = ci_cand;
            default: next_ci = ci_logic;
        endcase
    end

    // ------------------------------------------------------------------
    // Accumulators
    // ------------------------------------------------------------------
    // Execution wins over software loads; loads only land while idle
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_a <= '0;
            acc_b <= '0;
        end else if (state == LCE_EXEC) begin
            acc_a <= next_a;
            acc_b <= next_b;
        end else if (wr_take && paddr == OFS_ACC_A) begin
            acc_a <= pwdata;
        end else if (wr_take && paddr == OFS_ACC_B) begin
            acc_b <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // Condition indicator and status
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cond_ind <= CI_RESET;
        end else if (state == LCE_EXEC && ci_en) begin
            cond_ind <= next_ci;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
            illegal <= 1'b0;
        end else if (state == LCE_EXEC) begin
            done <= 1'b1;
            illegal <= next_illegal;
        end else if (go) begin
            done <= 1'b0;
            illegal <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Storage write port
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            store_wr <= 1'b0;
            store_dbl <= 1'b0;
            store_data <= '0;
        end else begin
            store_wr <= (state == LCE_EXEC) & next_store_wr;
            if (state == LCE_EXEC) begin
                store_data <= next_store;
                store_dbl <= next_store_dbl;
            end
        end
    end

endmodule : lce_exec

// ==== lce_exec_asserts.sv ====
// Port checker for the execution unit: bus timing, indicator and store pulses.
// Bound to lce_exec; sees only its ports.
`timescale 1ns/100ps
module lce_exec_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lce_pkg::PADDR_W-1:0] paddr,
    input wire logic [lce_pkg::WORD_W-1:0] pwdata,
    input wire logic [lce_pkg::WORD_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] cond_ind,
    input wire logic store_wr,
    input wire logic store_dbl,
    input wire logic [lce_pkg::DBL_W-1:0] store_data
);
    import lce_pkg::*;
    // ------
    // Launch decode
    // ------
    logic go;
    logic st_go;
    logic [7:0] opc;
    assign opc = pwdata[7:0];
    assign go = psel && penable && pready && pwrite && paddr == OFS_CTRL && pwdata[CTRL_GO_BIT];
    // Store launch with no literal and no index, the only legal form
    assign st_go = go && opc == 8'h65 && !pwdata[11] && pwdata[14:13] == 2'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RDY_LAT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready) else $error("wait state");
    AST_RDY_ONE: assert property (pready |=> !pready) else $error("pready too long");
    AST_ERR_MAP: assert property (pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0000_0000) else $error("map");
    AST_CI_CODE: assert property (cond_ind != 2'h0) else $error("indicator code");
    AST_CI_CAUSE: assert property ($changed(cond_ind) |-> $past(go, 2)) else $error("indicator moved");
    AST_ST_CAUSE: assert property (store_wr |-> $past(go, 2) && $past(opc, 2) inside {8'h65, 8'h3B})
        else $error("stray store");
    AST_ST_NOLIT: assert property (go && opc == 8'h65 && pwdata[11] |-> ##2 !store_wr) else $error("lit store");
    AST_ST_DBL: assert property (st_go && pwdata[9:8] == 2'h3 |-> ##2 store_wr && store_dbl)
        else $error("double store");
    AST_CMP_NOP: assert property (go && !pwdata[10] && opc inside {8'h34, 8'h17, 8'h10} |-> ##2 $stable(cond_ind))
        else $error("compare ran");
    cover property (st_go);
    cover property (store_wr && store_dbl);
    cover property (pslverr);
endmodule : lce_exec_asserts

bind lce_exec lce_exec_asserts u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond_ind(cond_ind),
    .store_wr(store_wr), .store_dbl(store_dbl), .store_data(store_data));

// ==== lce_store_model.sv ====
// Storage model: the one location the effective address points at.
// Assumes instruction control presents one target location per store.
`timescale 1ns/100ps
module lce_store_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic store_wr,
    input wire logic store_dbl,
    input wire logic [lce_pkg::DBL_W-1:0] store_data,
    output logic [lce_pkg::DBL_W-1:0] mem
);
    import lce_pkg::*;
    always_ff @(posedge clk) begin
        if (rst) begin
            mem <= 64'h0;
        end else if (store_wr) begin
            mem[31:0] <= store_data[31:0];
            if (store_dbl) begin
                mem[63:32] <= store_data[63:32];
            end
        end
    end
endmodule : lce_store_model

// ==== lce_exec_tb_top.sv ====
// Random and corner bench for the execution unit with the storage model.
// Assumes package, storage model and checker are compiled first.
`timescale 1ns/100ps
module lce_exec_tb_top;
    import lce_pkg::*;
    logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, ea, eb;
    logic [63:0] store_data, mem, r;
    logic [63:0] emem = 64'h0;
    logic [1:0] cond_ind;
    logic [1:0] eci = 2'h2;
    logic pready, pslverr, store_wr, store_dbl, er;
    int failures = 0, n_checks = 0, cyc = 0, seed = 3;
    lce_exec dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond_ind(cond_ind),
        .store_wr(store_wr), .store_dbl(store_dbl), .store_data(store_data));
    lce_store_model u_mem (.clk(clk), .rst(rst), .store_wr(store_wr), .store_dbl(store_dbl),
        .store_data(store_data), .mem(mem));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            conclude();
        end
    end
    // ------
    // Bus, compare and reference helpers
    // ------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask : chk
    function automatic logic [1:0] ci_of(input logic [63:0] v, input logic dbl);
        if (!dbl) v = {{32{v[31]}}, v[31:0]};
        return (&v) ? 2'h1 : (v == 64'h0) ? 2'h2 : 2'h3;
    endfunction : ci_of
    function automatic logic [1:0] cmp(input logic [63:0] x, input logic [63:0] y);
        return (x < y) ? 2'h1 : (x == y) ? 2'h2 : 2'h3;
    endfunction : cmp
    // Loads operands, launches one op, then checks accumulators, low status bits, indicator and storage
    task automatic run(input logic [7:0] op, input int mi, input logic c, input logic l, input logic [17:0] af,
        input int k);
        logic [1:0] m, cc;
        logic [31:0] a, b, lo, hi, w, h;
        logic [63:0] o, x, y;
        logic dbl;
        m = mi[1:0];
        a = $random(seed);
        b = $random(seed);
        lo = $random(seed);
        hi = $random(seed);
        w = (m == 2'h2) ? b : a;
        // Corner: operand equal to or inverse of the accumulator
        if (k != 0) {hi, lo} = (m == 2'h3) ? {a, b} : {a, w};
        if (k == 1) {hi, lo} = ~{hi, lo};
        apb(1'h1, OFS_ADDRF, {14'h0000, af});
        apb(1'h1, OFS_OPND_LO, lo);
        apb(1'h1, OFS_OPND_HI, hi);
        apb(1'h1, OFS_ACC_A, a);
        apb(1'h1, OFS_ACC_B, b);
        apb(1'h1, OFS_CTRL, {1'h1, 16'h0000, 2'h0, a[0], l, c, m, op});
        o = (l && op != 8'h3B) ? {{46{af[17]}}, af} : {hi, lo};
        dbl = m == 2'h3 && op != 8'h33 && op != 8'h23;
        x = dbl ? {a, b} : {32'h0000_0000, w};
        y = dbl ? o : {32'h0000_0000, o[31:0]};
        h = l ? af[15:0] : lo[15:0];
        ea = a;
        eb = b;
        r = x ^ y;
        case (op)
            8'h3B: r = ~((m == 2'h0) ? y : x);
            8'h33: begin
                if (m == 2'h3) h = {{16{h[15]}}, h[15:0]};
                ea = a ^ ((m == 2'h1) ? h << 16 : h);
                r = ea;
            end
            8'h23: begin
                ea = a ^ ({24'h00_0000, (l ? af[7:0] : lo[7:0])} << (8 * (3 - mi)));
                r = ea;
            end
            8'h34: cc = ((x & y) == y) ? 2'h1 : ((x & y) == 64'h0) ? 2'h2 : 2'h3;
            8'h17: cc = cmp(x, y);
            8'h10: cc = cmp((m == 2'h1) ? a[31:16] : a[15:0], h[15:0]);
            default: cc = 2'h0;
        endcase
        if (op == 8'h27 || (op == 8'h3B && m != 2'h0)) begin
            {ea, eb} = dbl ? r : (m == 2'h1) ? {r[31:0], b} : {a, r[31:0]};
        end
        if ((op == 8'h65 && !l) || (op == 8'h3B && m == 2'h0)) emem = dbl ? r : {emem[63:32], r[31:0]};
        if (c && !(op == 8'h65 && l)) eci = (op inside {8'h34, 8'h17, 8'h10}) ? cc : ci_of(r, dbl);
        apb(1'h0, OFS_ACC_A, 32'h0000_0000);
        chk("acc_a", ea, rd);
        apb(1'h0, OFS_ACC_B, 32'h0000_0000);
        chk("acc_b", eb, rd);
        apb(1'h0, OFS_STATUS, 32'h0000_0000);
        chk("status", {op == 8'h65 && l, 1'h1, eci}, rd[3:0]);
        chk("cond_ind", eci, cond_ind);
        chk("storage", emem, mem);
    endtask : run
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        apb(1'h0, OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0002, rd);
        apb(1'h0, 8'h24, 32'h0000_0000);
        chk("unmapped", 33'h0_0000_0001, {rd, er});
        for (int i = 0; i < 6; i++) begin
            for (int m = 0; m < 4; m++) begin
                if (m != 0) run(8'h27, m, i[1] | i[2], i[0], 18'($random(seed)), i % 3);
                if (m != 0) run(8'h33, m, 1'h1, i[0], 18'($random(seed)), 0);
                run(8'h23, m, 1'h1, i[0], 18'($random(seed)), 0);
                if (m != 0) run(8'h65, m, 1'h1, 1'h0, 18'h0_0000, i % 3);
                run(8'h3B, m, i[0], i[1], 18'($random(seed)), i % 3);
                if (m != 0) run(8'h34, m, 1'h1, i[0], 18'($random(seed)), i % 3);
                if (m != 0) run(8'h17, m, 1'h1, i[0], 18'($random(seed)), i % 3);
                if (m == 1 || m == 2) run(8'h10, m, 1'h1, i[0], 18'($random(seed)), i % 3);
            end
            run(8'h65, 1, 1'h1, 1'h1, 18'h0_0000, 0);
            run(8'h17, 3, 1'h0, 1'h0, 18'h0_0000, 2);
            $display("round %0d ended", i);
        end
        conclude();
    end
endmodule : lce_exec_tb_top
